//--- common/flash_burst_pkg.sv
package flash_burst_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int GROUP_BITS = 3;
  localparam int LINE_BITS = 7;
  localparam int BANK_BITS = 2;
  localparam int BANKS = 4;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_BUSY = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MEM_ADDR = 8'h0c;
  localparam logic [7:0] OFF_MEM_DATA = 8'h10;
  localparam logic [7:0] OFF_STAT_WORD = 8'h14;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_WAIT_LSB = 0;
  localparam int CFG_POL_BIT = 4;
  localparam int STS_ACTIVE_BIT = 0;
  localparam int STS_STATUS_BIT = 1;
  localparam int STS_ADDR_LSB = 16;
  localparam logic [3:0] WAIT_RESET = 4'hd;
  localparam logic RDY_POL_RESET = 1'b1;
  localparam logic [15:0] STAT_WORD_RESET = 16'h0080;

  // ----------------------------------------------------------------
  // latency figures, in link clock edges, and the largest short wait code
  // ----------------------------------------------------------------
  localparam logic [3:0] GAP_FREE_WS = 4'h9;
  localparam logic [3:0] WAIT_CODE_SHORT_MAX = 4'h5;
  localparam logic [3:0] SHORT_BASE_EDGES = 4'h2;
  localparam logic [3:0] DEFAULT_EDGES = 4'hd;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LAT = 3'h1,
    ST_STREAM = 3'h3,
    ST_GAP = 3'h2,
    ST_STAT = 3'h6,
    ST_ASYNC = 3'h4
  } burst_state_t;

  // wait code to rising edge that carries the first word
  function automatic logic [3:0] wait_edges(input logic [3:0] code);
    if (code <= WAIT_CODE_SHORT_MAX) begin
      wait_edges = code + SHORT_BASE_EDGES;
    end else if (code == 4'h8 || code == 4'h9) begin
      wait_edges = code;
    end else begin
      wait_edges = DEFAULT_EDGES;
    end
  endfunction

endpackage

//--- design/pin_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for a group of pin inputs
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      q <= RESET_VAL;
    end else if (en) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

//--- design/flash_burst_read_port.sv
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module flash_burst_read_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic link_clk,
  input wire logic address_valid_n,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic flash_reset_n,
  input wire logic [15:0] addr_data_bus_i,
  output logic [15:0] addr_data_bus_o,
  output logic addr_data_bus_oe,
  output logic ready_o,
  output logic ready_oe
);

  localparam int AW = flash_burst_pkg::ADDR_W;
  localparam int SYNC_W = 21;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 21'h0e0000;

  typedef struct packed {
    flash_burst_pkg::burst_state_t st;
    logic [AW-1:0] addr;
    logic [3:0] cnt;
    logic [2:0] start_off;
    logic group_done;
    logic rdy_act;
    logic [15:0] dout;
    logic clk_prev;
    logic avd_prev;
    logic [3:0] wait_code;
    logic rdy_pol;
    logic [3:0] busy;
    logic [15:0] status_word;
    logic [AW-1:0] mem_addr;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic rd_done;
    logic [31:0] hrdata;
  } regs_t;

  localparam regs_t REGS_RESET = '{
    st: flash_burst_pkg::ST_IDLE,
    addr: '0,
    cnt: 4'h0,
    start_off: 3'h0,
    group_done: 1'b0,
    rdy_act: 1'b0,
    dout: 16'h0000,
    clk_prev: 1'b0,
    avd_prev: 1'b1,
    wait_code: flash_burst_pkg::WAIT_RESET,
    rdy_pol: flash_burst_pkg::RDY_POL_RESET,
    busy: 4'h0,
    status_word: flash_burst_pkg::STAT_WORD_RESET,
    mem_addr: '0,
    dp_valid: 1'b0,
    dp_write: 1'b0,
    dp_addr: 8'h00,
    rd_done: 1'b0,
    hrdata: 32'h00000000
  };

  regs_t s_q;
  regs_t s_d;
  logic [15:0] mem [0:(1<<AW)-1];
  logic mem_we;
  logic [SYNC_W-1:0] sync_q;
  logic lk_clk;
  logic lk_avd_n;
  logic lk_ce_n;
  logic lk_oe_n;
  logic lk_rst_n;
  logic [15:0] lk_bus;
  logic rise;
  logic [3:0] ws;
  logic [AW-1:0] next_addr;
  logic [4:0] g8_sum;
  logic [3:0] gap8;
  logic [3:0] gap128;
  logic [3:0] gap;
  logic busy_cross;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // the link clock is sampled like any other pin; its edges are found below
  pin_sync #(.W(SYNC_W), .RESET_VAL(SYNC_RESET)) u_sync (
    .clk(clk),
    .rst(rst),
    .en(en),
    .d({flash_reset_n, output_enable_n, chip_enable_n, address_valid_n, link_clk,
        addr_data_bus_i}),
    .q(sync_q)
  );

  assign lk_bus = sync_q[15:0];
  assign lk_clk = sync_q[16];
  assign lk_avd_n = sync_q[17];
  assign lk_ce_n = sync_q[18];
  assign lk_oe_n = sync_q[19];
  assign lk_rst_n = sync_q[20];

  // ----------------------------------------------------------------
  // latency arithmetic
  // ----------------------------------------------------------------
  assign rise = lk_clk & ~s_q.clk_prev;
  assign ws = flash_burst_pkg::wait_edges(s_q.wait_code);
  assign next_addr = s_q.addr + {{(AW-1){1'b0}}, 1'b1};
  // idle cycles after D7 grow with start offset plus wait states past nine
  assign g8_sum = {2'b00, s_q.start_off} + {1'b0, ws};
  assign gap8 = (g8_sum > {1'b0, flash_burst_pkg::GAP_FREE_WS}) ?
                4'(g8_sum - {1'b0, flash_burst_pkg::GAP_FREE_WS}) : 4'h0;
  // line crossings cost nothing up to nine wait states
  assign gap128 = (ws > flash_burst_pkg::GAP_FREE_WS) ?
                  4'(ws - flash_burst_pkg::GAP_FREE_WS) : 4'h0;
  always_comb begin
    gap = 4'h0;
    if (s_q.addr[flash_burst_pkg::GROUP_BITS-1:0] == 3'h7 && !s_q.group_done) begin
      gap = gap8;
    end
    if (next_addr[flash_burst_pkg::LINE_BITS-1:0] == '0) begin
      gap = gap + gap128;
    end
  end
  assign busy_cross = s_q.busy[next_addr[AW-1 -: flash_burst_pkg::BANK_BITS]] &&
                      (next_addr[AW-1 -: flash_burst_pkg::BANK_BITS] !=
                       s_q.addr[AW-1 -: flash_burst_pkg::BANK_BITS]);

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h00000000;
    case (s_q.dp_addr)
      flash_burst_pkg::OFF_CONFIG: begin
        rd_mux[flash_burst_pkg::CFG_WAIT_LSB +: 4] = s_q.wait_code;
        rd_mux[flash_burst_pkg::CFG_POL_BIT] = s_q.rdy_pol;
      end
      flash_burst_pkg::OFF_BUSY: rd_mux[flash_burst_pkg::BANKS-1:0] = s_q.busy;
      flash_burst_pkg::OFF_STATUS: begin
        rd_mux[flash_burst_pkg::STS_ACTIVE_BIT] = (s_q.st != flash_burst_pkg::ST_IDLE) &&
                                                  (s_q.st != flash_burst_pkg::ST_ASYNC);
        rd_mux[flash_burst_pkg::STS_STATUS_BIT] = (s_q.st == flash_burst_pkg::ST_STAT);
        rd_mux[flash_burst_pkg::STS_ADDR_LSB +: AW] = s_q.addr;
      end
      flash_burst_pkg::OFF_MEM_ADDR: rd_mux[AW-1:0] = s_q.mem_addr;
      flash_burst_pkg::OFF_MEM_DATA: rd_mux[15:0] = mem[s_q.mem_addr];
      flash_burst_pkg::OFF_STAT_WORD: rd_mux[15:0] = s_q.status_word;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    mem_we = 1'b0;
    s_d.clk_prev = lk_clk;
    s_d.avd_prev = lk_avd_n;
    if (lk_ce_n || !lk_rst_n) begin
      s_d.st = flash_burst_pkg::ST_IDLE;
      s_d.rdy_act = 1'b0;
    end else if (rise && !lk_avd_n) begin
      // a strobe aborts whatever runs, a busy-bank status read included
      s_d.st = flash_burst_pkg::ST_LAT;
      s_d.addr = lk_bus[AW-1:0];
      s_d.start_off = lk_bus[flash_burst_pkg::GROUP_BITS-1:0];
      s_d.cnt = 4'h0;
      s_d.group_done = 1'b0;
      s_d.rdy_act = 1'b0;
    end else begin
      case (s_q.st)
        flash_burst_pkg::ST_IDLE: begin
          if (!lk_avd_n) begin
            s_d.addr = lk_bus[AW-1:0];
          end else if (!s_q.avd_prev) begin
            // strobe rose without a clock edge: plain asynchronous read
            s_d.st = flash_burst_pkg::ST_ASYNC;
            s_d.dout = mem[s_q.addr];
            s_d.rdy_act = 1'b1;
          end
        end
        flash_burst_pkg::ST_ASYNC: begin
          if (!lk_avd_n) begin
            s_d.st = flash_burst_pkg::ST_IDLE;
            s_d.addr = lk_bus[AW-1:0];
            s_d.rdy_act = 1'b0;
          end
        end
        flash_burst_pkg::ST_LAT: begin
          if (rise) begin
            if (s_q.cnt + 4'h1 == ws) begin
              s_d.st = flash_burst_pkg::ST_STREAM;
              s_d.dout = mem[s_q.addr];
              s_d.rdy_act = 1'b1;
            end else begin
              s_d.cnt = s_q.cnt + 4'h1;
            end
          end
        end
        flash_burst_pkg::ST_STREAM: begin
          if (rise) begin
            s_d.addr = next_addr;
            if (s_q.addr[flash_burst_pkg::GROUP_BITS-1:0] == 3'h7) begin
              s_d.group_done = 1'b1;
            end
            if (busy_cross) begin
              s_d.st = flash_burst_pkg::ST_STAT;
              s_d.dout = s_q.status_word;
            end else if (gap != 4'h0) begin
              s_d.st = flash_burst_pkg::ST_GAP;
              s_d.cnt = gap;
              s_d.rdy_act = 1'b0;
            end else begin
              s_d.dout = mem[next_addr];
            end
          end
        end
        flash_burst_pkg::ST_GAP: begin
          if (rise) begin
            if (s_q.cnt == 4'h1) begin
              s_d.st = flash_burst_pkg::ST_STREAM;
              s_d.dout = mem[s_q.addr];
              s_d.rdy_act = 1'b1;
            end else begin
              s_d.cnt = s_q.cnt - 4'h1;
            end
          end
        end
        // status stays on the bus; the clock is ignored until a new strobe
        flash_burst_pkg::ST_STAT: s_d.st = flash_burst_pkg::ST_STAT;
        default: s_d.st = flash_burst_pkg::ST_IDLE;
      endcase
    end

    // bus data phase: writes land here, reads take one extra cycle so the
    // returned word always reflects any write just before it
    if (s_q.dp_valid && s_q.dp_write && hready) begin
      case (s_q.dp_addr)
        flash_burst_pkg::OFF_CONFIG: begin
          s_d.wait_code = hwdata[flash_burst_pkg::CFG_WAIT_LSB +: 4];
          s_d.rdy_pol = hwdata[flash_burst_pkg::CFG_POL_BIT];
        end
        flash_burst_pkg::OFF_BUSY: s_d.busy = hwdata[flash_burst_pkg::BANKS-1:0];
        flash_burst_pkg::OFF_MEM_ADDR: s_d.mem_addr = hwdata[AW-1:0];
        flash_burst_pkg::OFF_MEM_DATA: begin
          mem_we = 1'b1;
          s_d.mem_addr = s_q.mem_addr + {{(AW-1){1'b0}}, 1'b1};
        end
        flash_burst_pkg::OFF_STAT_WORD: s_d.status_word = hwdata[15:0];
        default: s_d.busy = s_q.busy;
      endcase
    end
    if (s_q.dp_valid && !s_q.dp_write && !s_q.rd_done) begin
      s_d.hrdata = rd_mux;
      s_d.rd_done = 1'b1;
      if (s_q.dp_addr == flash_burst_pkg::OFF_MEM_DATA) begin
        s_d.mem_addr = s_q.mem_addr + {{(AW-1){1'b0}}, 1'b1};
      end
    end else if (hready) begin
      s_d.dp_valid = hsel && htrans[1];
      s_d.dp_write = hwrite;
      s_d.dp_addr = haddr[7:0];
      s_d.rd_done = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= REGS_RESET;
    end else if (en) begin
      s_q <= s_d;
    end
  end

  // array contents survive reset, like the cells they stand for
  always_ff @(posedge clk) begin
    if (en && mem_we && !rst) begin
      mem[s_q.mem_addr] <= hwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout = !(s_q.dp_valid && !s_q.dp_write && !s_q.rd_done);
  assign hresp = 1'b0;
  assign hrdata = s_q.hrdata;
  assign addr_data_bus_o = s_q.dout;
  assign addr_data_bus_oe = !lk_ce_n && lk_rst_n && !lk_oe_n &&
                            (s_q.st == flash_burst_pkg::ST_STREAM ||
                             s_q.st == flash_burst_pkg::ST_GAP ||
                             s_q.st == flash_burst_pkg::ST_STAT ||
                             s_q.st == flash_burst_pkg::ST_ASYNC);
  assign ready_o = s_q.rdy_act ? s_q.rdy_pol : !s_q.rdy_pol;
  assign ready_oe = !lk_ce_n && lk_rst_n;

endmodule

//--- bench/flash_burst_checker.sv
`timescale 1ns/100ps
module flash_burst_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic link_clk,
  input wire logic address_valid_n,
  input wire logic chip_enable_n,
  input wire logic flash_reset_n,
  input wire logic addr_data_bus_oe,
  input wire logic ready_o,
  input wire logic ready_oe
);
  logic take, cfg_q, pol_q;
  logic [2:0] pins_q;
  logic [3:0] since_q;
  assign take = hready && hsel && htrans[1];
  // polarity is mirrored from bus writes so ready can be judged active or idle
  always_ff @(posedge clk) begin
    pins_q <= {link_clk, address_valid_n, chip_enable_n};
    if (rst) begin
      cfg_q <= 1'b0;
      pol_q <= flash_burst_pkg::RDY_POL_RESET;
      since_q <= 4'h0;
    end else begin
      cfg_q <= take && hwrite && haddr[7:0] == flash_burst_pkg::OFF_CONFIG;
      if (cfg_q) begin
        pol_q <= hwdata[flash_burst_pkg::CFG_POL_BIT];
      end
      if (pins_q != {link_clk, address_valid_n, chip_enable_n}) begin
        since_q <= 4'h0;
      end else if (since_q != 4'hf) begin
        since_q <= since_q + 4'h1;
      end
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not two cycles");
  write_done_a: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  unmapped_zero_a: assert property (take && !hwrite && haddr[7:0] == 8'h20 |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  ce_float_a: assert property (chip_enable_n [*4] |-> !addr_data_bus_oe && !ready_oe)
    else $error("outputs driven while deselected");
  reset_float_a: assert property (!flash_reset_n [*4] |-> !addr_data_bus_oe && !ready_oe)
    else $error("outputs driven during pin reset");
  latency_idle_a: assert property ($rose(link_clk) && !address_valid_n
    && !chip_enable_n && flash_reset_n |-> ##6 ready_o != pol_q)
    else $error("ready active during initial latency");
  edge_only_a: assert property (ready_oe && $past(ready_oe) && $stable(pol_q)
    && $changed(ready_o) |-> since_q <= 4'h7)
    else $error("ready moved away from a link edge");
endmodule

//--- bench/flash_host_model.sv
`timescale 1ns/100ps
module flash_host_model (
  output logic link_clk,
  output logic address_valid_n,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic flash_reset_n,
  output logic [15:0] addr_data_bus_i,
  input wire logic [15:0] addr_data_bus_o,
  input wire logic addr_data_bus_oe,
  input wire logic ready_o
);
  logic [15:0] host_q = 16'h5555;
  logic [15:0] got_d [$];
  logic got_r [$];
  // a released bus shows host_q: the inverted address in a burst, but the held address in an async read
  assign addr_data_bus_i = addr_data_bus_oe ? addr_data_bus_o : host_q;
  initial begin
    link_clk = 1'b0;
    address_valid_n = 1'b1;
    chip_enable_n = 1'b1;
    output_enable_n = 1'b1;
    flash_reset_n = 1'b1;
  end
  task automatic burst(input logic [9:0] a, input int n);
    got_d.delete();
    got_r.delete();
    // pins move off the system clock edge so the synchronisers see no race
    #5;
    output_enable_n = 1'b1;
    chip_enable_n = 1'b0;
    address_valid_n = 1'b0;
    host_q = {6'h0, a};
    #80 link_clk = 1'b1;
    #80 link_clk = 1'b0;
    address_valid_n = 1'b1;
    host_q = ~host_q;
    output_enable_n = 1'b0;
    #80;
    // the clock runs only inside a frame and rests low afterwards
    repeat (n) begin
      link_clk = 1'b1;
      #80 link_clk = 1'b0;
      #70 got_d.push_back(addr_data_bus_o);
      got_r.push_back(ready_o);
      #10;
    end
  endtask
  // strobe rises with the link clock at rest: a plain asynchronous read
  task automatic async_read(input logic [9:0] a);
    got_d.delete();
    got_r.delete();
    #5;
    chip_enable_n = 1'b0;
    address_valid_n = 1'b0;
    host_q = {6'h0, a};
    #80 address_valid_n = 1'b1;
    #80 output_enable_n = 1'b0;
    #160 got_d.push_back(addr_data_bus_o);
    got_r.push_back(ready_o);
  endtask
  task automatic stop(input logic by_reset);
    flash_reset_n = !by_reset;
    output_enable_n = 1'b1;
    #400 chip_enable_n = 1'b1;
    flash_reset_n = 1'b1;
    host_q = ~host_q;
  endtask
endmodule

//--- bench/tb_flash_burst_read_port.sv
`timescale 1ns/100ps
module tb_flash_burst_read_port;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, lclk, avd_n, ce_n, oe_n, frst_n, bus_oe, rdy, rdy_oe;
  logic [31:0] hrdata, r;
  logic [15:0] bus_i, bus_o;
  int errors = 0;
  int compares = 0;
  logic [4:0] cfgs [11] = '{5'h1d, 5'h19, 5'h18, 5'h18, 5'h13, 5'h13, 5'h10, 5'h10, 5'h01,
    5'h10, 5'h10};
  logic [9:0] addrs [11] = '{10'h010, 10'h003, 10'h006, 10'h001, 10'h045, 10'h044, 10'h07c,
    10'h3fe, 10'h020, 10'h0fe, 10'h010};
  int lens [11] = '{20, 20, 20, 14, 14, 12, 10, 6, 6, 5, 5};
  always #10 clk = ~clk;
  flash_burst_read_port flash_burst_read_port_inst (.clk(clk), .rst(rst), .en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .link_clk(lclk), .address_valid_n(avd_n), .chip_enable_n(ce_n),
    .output_enable_n(oe_n), .flash_reset_n(frst_n), .addr_data_bus_i(bus_i),
    .addr_data_bus_o(bus_o), .addr_data_bus_oe(bus_oe), .ready_o(rdy), .ready_oe(rdy_oe));
  flash_host_model flash_host_model_inst (.link_clk(lclk), .address_valid_n(avd_n),
    .chip_enable_n(ce_n), .output_enable_n(oe_n), .flash_reset_n(frst_n),
    .addr_data_bus_i(bus_i), .addr_data_bus_o(bus_o), .addr_data_bus_oe(bus_oe), .ready_o(rdy));
  task automatic report_and_stop;
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // hready is sampled at each rising edge, the same edge at which the slave acts
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      @(posedge clk);
    end
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      @(posedge clk);
    end
    r = hrdata;
  endtask
  function automatic logic [15:0] pat(input logic [9:0] a);
    pat = {~a[5:0], a};
  endfunction
  task automatic run(input logic [4:0] cfg, input logic [9:0] a, input int n,
    input logic [3:0] busy);
    int ws, gap, e;
    logic [9:0] cur;
    logic [15:0] exp_d;
    logic seven, act;
    ws = cfg[3:0] <= 4'h5 ? int'(cfg[3:0]) + 2 : int'(cfg[3:0]);
    gap = int'(a[2:0]) + ws - 9;
    cur = a;
    seven = 1'b0;
    exp_d = 16'h0;
    flash_host_model_inst.burst(a, n);
    for (e = 1; e <= n; e++) begin
      act = e >= ws && !(seven && gap > 0);
      if (act) begin
        exp_d = busy[cur[9:8]] ? flash_burst_pkg::STAT_WORD_RESET : pat(cur);
        seven = seven || cur[2:0] == 3'h7;
        cur = cur + 10'h1;
      end else if (seven) begin
        gap = gap - 1;
      end
      check("ready", {31'h0, flash_host_model_inst.got_r[e-1]}, {31'h0, act ~^ cfg[4]});
      if (e >= ws) begin
        check("word", {16'h0, flash_host_model_inst.got_d[e-1]}, {16'h0, exp_d});
      end
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    ahb(1'b0, flash_burst_pkg::OFF_CONFIG, 32'h0);
    check("config", r, {27'h0, flash_burst_pkg::RDY_POL_RESET, flash_burst_pkg::WAIT_RESET});
    ahb(1'b0, flash_burst_pkg::OFF_STAT_WORD, 32'h0);
    check("stat_word", r, {16'h0, flash_burst_pkg::STAT_WORD_RESET});
    ahb(1'b1, 8'h20, 32'hffff_ffff);
    ahb(1'b0, 8'h20, 32'h0);
    check("unmapped", r, 32'h0);
    ahb(1'b1, flash_burst_pkg::OFF_MEM_ADDR, 32'h0);
    for (int i = 0; i < 1024; i++) begin
      ahb(1'b1, flash_burst_pkg::OFF_MEM_DATA, {16'h0, pat(i[9:0])});
    end
    ahb(1'b1, flash_burst_pkg::OFF_MEM_ADDR, 32'h123);
    ahb(1'b0, flash_burst_pkg::OFF_MEM_DATA, 32'h0);
    check("mem_data", r, {16'h0, pat(10'h123)});
    ahb(1'b0, flash_burst_pkg::OFF_MEM_ADDR, 32'h0);
    check("mem_addr", r, 32'h124);
    for (int i = 0; i < 11; i++) begin
      if (i == 9) begin
        ahb(1'b1, flash_burst_pkg::OFF_BUSY, 32'h2);
      end
      if (i > 0 && i != 10) begin
        // a bus write stands in for the unlock and command cycles on the pins
        ahb(1'b1, flash_burst_pkg::OFF_CONFIG, {27'h0, cfgs[i]});
      end
      run(cfgs[i], addrs[i], lens[i], i >= 9 ? 4'h2 : 4'h0);
      if (i != 9) begin
        flash_host_model_inst.stop(i[0]);
        repeat (6) @(posedge clk);
        check("bus_oe", {31'h0, bus_oe}, 32'h0);
        check("ready_oe", {31'h0, rdy_oe}, 32'h0);
      end else begin
        ahb(1'b0, flash_burst_pkg::OFF_STATUS, 32'h0);
        check("status", r, {6'h0, 10'h100, 14'h0, 2'h3});
        ahb(1'b0, flash_burst_pkg::OFF_BUSY, 32'h0);
        check("busy", r, 32'h2);
      end
    end
    flash_host_model_inst.async_read(10'h155);
    check("async_word", {16'h0, flash_host_model_inst.got_d[0]}, {16'h0, pat(10'h155)});
    check("async_ready", {31'h0, flash_host_model_inst.got_r[0]}, 32'h1);
    check("async_oe", {31'h0, bus_oe}, 32'h1);
    flash_host_model_inst.stop(1'b0);
    repeat (6) @(posedge clk);
    check("async_end", {31'h0, bus_oe}, 32'h0);
    report_and_stop();
  end
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
endmodule
bind flash_burst_read_port flash_burst_checker flash_burst_checker_inst (.clk(clk), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .link_clk(link_clk), .address_valid_n(address_valid_n), .chip_enable_n(chip_enable_n),
  .flash_reset_n(flash_reset_n), .addr_data_bus_oe(addr_data_bus_oe), .ready_o(ready_o),
  .ready_oe(ready_oe));
